// ==== core/bosa_alu.v ====
// Execution datapath: OR literal/file, increment, logical shifts
//
// Contract
// - OR literal into accumulator: acc | 8-bit literal to acc, zero flag updated.
// - OR accumulator with file: result to chosen destination, only zero flag updated.
// - Increment file: file + 1 to chosen destination, zero updated, carry untouched.
// - File ops take 7-bit address; dest 0 writes accumulator, 1 writes file.
// - Left shift: bit 7 to carry, bits 6:0 to result 7:1, zero updated.
// - Left shift result bit 0 is always zero.
// - Right shift: bit 0 to carry, bits 7:1 to result 6:0, zero updated.
// - Right shift result bit 7 is always zero.
`timescale 1ns/1ps
`default_nettype none
`include "bosa_map.vh"

module bosa_alu #(
   parameter DW = `BOSA_DATA_W,
   parameter AW = `BOSA_ADDR_W
) (
   input wire i_clk,
   input wire i_reset_n,
   input wire i_valid,
   input wire [`BOSA_OP_W-1:0] i_op,
   input wire i_dest,
   input wire [AW-1:0] i_file_addr,
   input wire [DW-1:0] i_literal,
   input wire [DW-1:0] i_file_data,
   output wire [DW-1:0] o_acc,
   output wire o_zero,
   output wire o_carry,
   output wire o_file_we,
   output wire [AW-1:0] o_file_addr,
   output wire [DW-1:0] o_file_wdata,
   output wire o_done
);

   // ********************************************************************
   // State registers and their next values
   // ********************************************************************
   reg [DW-1:0] acc_r;
   reg [DW-1:0] acc_nxt;
   reg zero_r;
   reg zero_nxt;
   reg carry_r;
   reg carry_nxt;
   reg file_we_r;
   reg file_we_nxt;
   reg [AW-1:0] file_addr_r;
   reg [AW-1:0] file_addr_nxt;
   reg [DW-1:0] file_wdata_r;
   reg [DW-1:0] file_wdata_nxt;
   reg done_r;
   reg done_nxt;

   // ********************************************************************
   // Operation decode
   // ********************************************************************
   reg known_op;
   reg dest_fixed;

   // Literal form has no file operand, so its destination is fixed
   always @* begin
      known_op = 1'b0;
      dest_fixed = 1'b0;
      case (i_op)
         `BOSA_OP_OR_LIT: begin
            known_op = 1'b1;
            dest_fixed = 1'b1;
         end
         `BOSA_OP_OR_FILE: begin
            known_op = 1'b1;
         end
         `BOSA_OP_INC_FILE: begin
            known_op = 1'b1;
         end
         `BOSA_OP_SHL: begin
            known_op = 1'b1;
         end
         `BOSA_OP_SHR: begin
            known_op = 1'b1;
         end
         default: begin
            // Spare codes are no-ops
            known_op = 1'b0;
         end
      endcase
   end

   wire go = i_valid && known_op;
   // Refused requests leave acc, flags, file address and data as they were; done and write strobe clear
   wire to_file = go && !dest_fixed && (i_dest == `BOSA_DEST_FILE);
   wire to_acc = go && !to_file;

   // ********************************************************************
   // Result computation
   // ********************************************************************
   wire [DW-1:0] result;
   wire res_carry;
   wire res_zero;
   wire touch_carry;

   // Accumulator and carry operands are the registered values, so back-to-back ops chain
   bosa_result_unit #(
      .DW(DW)
   ) bosa_result_unit_i (
      .i_op(i_op),
      .i_acc(acc_r),
      .i_lit(i_literal),
      .i_file(i_file_data),
      .i_carry(carry_r),
      .o_result(result),
      .o_carry(res_carry),
      .o_zero(res_zero),
      .o_touch_carry(touch_carry)
   );

   // ********************************************************************
   // Next-state logic
   // ********************************************************************
   // Accumulator only moves when it is the destination
   always @* begin
      acc_nxt = acc_r;
      if (to_acc) begin
         acc_nxt = result;
      end
   end

   always @* begin
      zero_nxt = zero_r;
      if (go) begin
         zero_nxt = res_zero;
      end
   end

   // Carry only moves on shifts; OR and increment leave it
   always @* begin
      carry_nxt = carry_r;
      if (go && touch_carry) begin
         carry_nxt = res_carry;
      end
   end

   // Write strobe is a one-cycle pulse
   always @* begin
      file_we_nxt = to_file;
   end

   // Address and data hold until the next write for the file side
   always @* begin
      file_addr_nxt = file_addr_r;
      file_wdata_nxt = file_wdata_r;
      if (to_file) begin
         file_addr_nxt = i_file_addr;
         file_wdata_nxt = result;
      end
   end

   always @* begin
      done_nxt = go;
   end

   // ********************************************************************
   // Registers
   // ********************************************************************
   // Synchronous reset; one edge clears everything
   always @(posedge i_clk) begin
      if (!i_reset_n) begin
         acc_r <= `BOSA_ACC_RST;
      end else begin
         acc_r <= acc_nxt;
      end
   end

   always @(posedge i_clk) begin
      if (!i_reset_n) begin
         zero_r <= `BOSA_FLAG_RST;
      end else begin
         zero_r <= zero_nxt;
      end
   end

   always @(posedge i_clk) begin
      if (!i_reset_n) begin
         carry_r <= `BOSA_FLAG_RST;
      end else begin
         carry_r <= carry_nxt;
      end
   end

   always @(posedge i_clk) begin
      if (!i_reset_n) begin
         file_we_r <= `BOSA_PULSE_RST;
      end else begin
         file_we_r <= file_we_nxt;
      end
   end

   always @(posedge i_clk) begin
      if (!i_reset_n) begin
         file_addr_r <= `BOSA_ADDR_RST;
      end else begin
         file_addr_r <= file_addr_nxt;
      end
   end

   always @(posedge i_clk) begin
      if (!i_reset_n) begin
         file_wdata_r <= `BOSA_ZERO_BYTE;
      end else begin
         file_wdata_r <= file_wdata_nxt;
      end
   end

   always @(posedge i_clk) begin
      if (!i_reset_n) begin
         done_r <= `BOSA_PULSE_RST;
      end else begin
         done_r <= done_nxt;
      end
   end

   // ********************************************************************
   // Outputs
   // ********************************************************************
   // Every output comes straight from a flip-flop
   assign o_acc = acc_r;
   assign o_zero = zero_r;
   assign o_carry = carry_r;
   assign o_file_we = file_we_r;
   assign o_file_addr = file_addr_r;
   assign o_file_wdata = file_wdata_r;
   assign o_done = done_r;

endmodule
`default_nettype wire

// ==== pkg/bosa_map.vh ====
// Constants for the byte OR / increment / shift execution datapath
`ifndef BOSA_MAP_VH
`define BOSA_MAP_VH

// ********************************************************************
// Operation codes from the decoder
// ********************************************************************
`define BOSA_OP_W 3
`define BOSA_OP_NONE 3'h0
`define BOSA_OP_OR_LIT 3'h1
`define BOSA_OP_OR_FILE 3'h2
`define BOSA_OP_INC_FILE 3'h3
`define BOSA_OP_SHL 3'h4
`define BOSA_OP_SHR 3'h5

// ********************************************************************
// Widths, destination encoding and reset values
// ********************************************************************
`define BOSA_DATA_W 8
`define BOSA_ADDR_W 7
`define BOSA_DEST_ACC 1'b0
`define BOSA_DEST_FILE 1'b1
`define BOSA_ACC_RST 8'h00
`define BOSA_FLAG_RST 1'b0
`define BOSA_PULSE_RST 1'b0
`define BOSA_ADDR_RST 7'h00
`define BOSA_MSB 7
`define BOSA_ONE 8'h01
`define BOSA_ZERO_BYTE 8'h00

`endif

// ==== core/bosa_result_unit.v ====
// Combinational result and flag unit for the execution datapath
`timescale 1ns/1ps
`default_nettype none
`include "bosa_map.vh"

module bosa_result_unit #(
   parameter DW = `BOSA_DATA_W
) (
   input wire [`BOSA_OP_W-1:0] i_op,
   input wire [DW-1:0] i_acc,
   input wire [DW-1:0] i_lit,
   input wire [DW-1:0] i_file,
   input wire i_carry,
   output reg [DW-1:0] o_result,
   output reg o_carry,
   output reg o_zero,
   output reg o_touch_carry
);

   always @* begin
      o_result = i_acc;
      o_carry = i_carry;
      o_touch_carry = 1'b0;
      case (i_op)
         `BOSA_OP_OR_LIT: begin
            o_result = i_acc | i_lit;
         end
         `BOSA_OP_OR_FILE: begin
            o_result = i_acc | i_file;
         end
         `BOSA_OP_INC_FILE: begin
            // Wraps 255 to 0; carry left alone
            o_result = i_file + `BOSA_ONE;
         end
         `BOSA_OP_SHL: begin
            o_carry = i_file[DW-1];
            o_result = {i_file[DW-2:0], 1'b0};
            o_touch_carry = 1'b1;
         end
         `BOSA_OP_SHR: begin
            o_carry = i_file[0];
            o_result = {1'b0, i_file[DW-1:1]};
            o_touch_carry = 1'b1;
         end
         default: begin
            o_result = i_acc;
         end
      endcase
      o_zero = (o_result == {DW{1'b0}});
   end

endmodule
`default_nettype wire

// ==== tb/bosa_alu_checker.sv ====
// Checker for the execution datapath
`timescale 1ns/1ps
`default_nettype none
module bosa_alu_checker(input wire i_clk,input wire i_reset_n,input wire i_valid,
input wire [2:0] i_op,input wire i_dest,input wire [6:0] i_file_addr,
input wire [7:0] i_literal,input wire [7:0] i_file_data,input wire [7:0] o_acc,
input wire o_zero,input wire o_carry,input wire o_file_we,input wire [6:0] o_file_addr,
input wire [7:0] o_file_wdata,input wire o_done);
// Requests without i_valid fold into op 0
wire [2:0] k=i_valid?i_op:3'h0;
wire g=k!=3'h0&&k<3'h6;
wire f=k>3'h1&&k<3'h6;
default clocking @(posedge i_clk); endclocking
default disable iff (!i_reset_n);
done_pulse_a: assert property (g|=>o_done) else $error("no done");
idle_hold_a: assert property (!g|=>!o_done&&!o_file_we&&$stable(o_acc))
   else $error("refused op acted");
zero_flag_a: assert property (g|=>o_zero==((o_file_we?o_file_wdata:o_acc)==8'h00))
   else $error("zero wrong");
or_literal_a: assert property (k==3'h1|=>o_acc==($past(o_acc)|$past(i_literal)))
   else $error("or literal wrong");
carry_kept_a: assert property (k==3'h2||k==3'h3|=>$stable(o_carry))
   else $error("carry moved");
dest_acc_a: assert property (f&&!i_dest|=>!o_file_we) else $error("file written");
dest_file_a: assert property (f&&i_dest|=>o_file_we&&o_file_addr==$past(i_file_addr))
   else $error("no file write");
shift_left_a: assert property (k==3'h4&&i_dest|=>o_carry==$past(i_file_data[7])
   &&o_file_wdata=={$past(i_file_data[6:0]),1'b0}) else $error("left shift wrong");
shift_right_a: assert property (k==3'h5&&!i_dest|=>o_carry==$past(i_file_data[0])
   &&o_acc=={1'b0,$past(i_file_data[7:1])}) else $error("right shift wrong");
cover property (k==3'h4&&i_dest);
cover property (k==3'h3&&i_file_data==8'hFF);
cover property (k==3'h2&&!i_dest);
endmodule
bind bosa_alu bosa_alu_checker bosa_alu_checker_i(.*);
`default_nettype wire

// ==== tb/bosa_file_model.sv ====
// File register bank on the far side of the datapath
`timescale 1ns/1ps
`default_nettype none
module bosa_file_model(input wire i_clk,input wire i_we,input wire [6:0] i_waddr,
input wire [7:0] i_wdata,input wire [6:0] i_raddr,output logic [7:0] o_rdata);
logic [7:0] mem [128];
initial for (int a=0;a<128;a++) mem[a]=8'(a*67);
always @(posedge i_clk) if (i_we) mem[i_waddr]<=i_wdata;
assign o_rdata=mem[i_raddr];
endmodule
`default_nettype wire

// ==== tb/test_byte_or_inc_shift_alu.sv ====
// Self-checking bench for the execution datapath
`timescale 1ns/1ps
`default_nettype none
module test_byte_or_inc_shift_alu;
logic i_clk=0,i_reset_n=0,i_valid=0,i_dest=0,z=0,c=0,we=0,d,dn=0;
logic [2:0] i_op=0,k;
logic [6:0] i_file_addr=0,wa=0;
logic [7:0] i_literal=0,acc=0,r,wd=0;
wire [7:0] fd,o_acc,o_file_wdata;
wire [6:0] o_file_addr;
wire o_zero,o_carry,o_file_we,o_done;
logic [31:0] lf=32'hE8EB;
int error_cnt=0,n_tests=0;
always #12.5 i_clk=~i_clk;
bosa_alu bosa_alu_i(.i_clk,.i_reset_n,.i_valid,.i_op,.i_dest,.i_file_addr,.i_literal,
   .i_file_data(fd),.o_acc,.o_zero,.o_carry,.o_file_we,.o_file_addr,.o_file_wdata,.o_done);
bosa_file_model bosa_file_model_i(.i_clk,.i_we(o_file_we),.i_waddr(o_file_addr),
   .i_wdata(o_file_wdata),.i_raddr(i_file_addr),.o_rdata(fd));
function automatic [31:0] nx(input [31:0] s);
   nx={s[30:0],s[31]^s[21]^s[1]^s[0]};
endfunction
task automatic cmp(input string n,input logic [7:0] e,input logic [7:0] g);
   n_tests++;
   if (g!==e) begin
      error_cnt++;
      $display("FAIL %s exp %h got %h",n,e,g);
   end
endtask
task automatic results;
   $display("checks %0d errors %0d",n_tests,error_cnt);
   if (error_cnt==0&&n_tests>0) $display("Finished cleanly");
   else $display("Finished with errors");
   $finish;
endtask
// ****************************************
// Back-to-back random ops, few addresses so results chain
// ****************************************
initial begin
   repeat(2) @(posedge i_clk);
   i_reset_n<=1;
   for (int n=0;n<3000;n++) begin
      @(posedge i_clk);
      lf=nx(lf);
      i_valid<=lf[3]|lf[4];
      i_op<=lf[7:5];
      i_dest<=lf[8];
      i_file_addr<=7'(lf[11:9]);
      i_literal<=lf[19:12];
      i_reset_n<=(n!=1500); // Mid-run reset, one edge long
      #1 cmp("acc",acc,o_acc);
      cmp("zero",{7'h00,z},{7'h00,o_zero});
      cmp("carry",{7'h00,c},{7'h00,o_carry});
      cmp("done",{7'h00,dn},{7'h00,o_done});
      cmp("we",{7'h00,we},{7'h00,o_file_we});
      if (we) cmp("wdata",wd,o_file_wdata);
      if (we) cmp("addr",{1'b0,wa},{1'b0,o_file_addr});
      k=lf[7:5];
      d=lf[8]&&k!=3'h1;
      dn=(lf[3]|lf[4])&&k!=3'h0&&k<3'h6;
      we=0;
      if (dn) begin
         case (k)
            3'h1: r=acc|lf[19:12];
            3'h2: r=acc|fd;
            3'h3: r=fd+8'h01;
            3'h4: begin c=fd[7]; r=fd<<1; end
            default: begin c=fd[0]; r=fd>>1; end
         endcase
         z=r==8'h00;
         if (d) begin we=1; wa=7'(lf[11:9]); wd=r; end
         else acc=r;
      end
      if (n==1500) begin
         acc=0;
         z=0;
         c=0;
         dn=0;
         we=0;
      end
   end
   results();
end
endmodule
`default_nettype wire
